// ==== hdl/lcdirq_map.svh ====
// Register map, field positions and reset values of the LCD interrupt test and write-protect bank.
// Assumes byte addressing on a 32-bit APB, one aligned word per register.
`ifndef LCDIRQ_MAP_SVH
`define LCDIRQ_MAP_SVH

// Interrupt register byte addresses.
`define LCDIRQ_ADDR_ENABLE_SET 32'h0050_0848
`define LCDIRQ_ADDR_ENABLE_CLR 32'h0050_084C
`define LCDIRQ_ADDR_MASK 32'h0050_0850
`define LCDIRQ_ADDR_STATUS 32'h0050_0854
`define LCDIRQ_ADDR_CLEAR 32'h0050_0858
`define LCDIRQ_ADDR_FORCE 32'h0050_0860
`define LCDIRQ_ADDR_RAW 32'h0050_0864

// Write-protect register byte addresses.
`define LCDIRQ_ADDR_PROT_MODE 32'h0050_08E4
`define LCDIRQ_ADDR_PROT_REPORT 32'h0050_08E8

// Protected configuration words start here, one word each.
`define LCDIRQ_ADDR_CFG_BASE 32'h0050_0800
`define LCDIRQ_CFG_COUNT 15
`define LCDIRQ_CFG_IDX_W 4

// Flag bit positions shared by every interrupt register.
`define LCDIRQ_BIT_LINE 0
`define LCDIRQ_BIT_FINAL_LINE 1
`define LCDIRQ_BIT_FRAME_DONE 2
`define LCDIRQ_BIT_UNDERFLOW 4
`define LCDIRQ_BIT_OVERWRITE 5
`define LCDIRQ_BIT_MEM_FAULT 6

// Protect mode register fields.
`define LCDIRQ_BIT_PROTECT_ON 0
`define LCDIRQ_KEY_LSB 8
`define LCDIRQ_KEY_MSB 31
`define LCDIRQ_KEY_VALUE 24'h4C4344

// Protect report register fields.
`define LCDIRQ_BIT_VIOLATION_SEEN 0
`define LCDIRQ_SRC_LSB 8
`define LCDIRQ_SRC_MSB 23

// Reset values.
`define LCDIRQ_RST_WORD 32'h0000_0000
`define LCDIRQ_RST_FLAGS 6'h00

`endif

// ==== hdl/lcdirq_pkg.sv ====
// Types of the LCD interrupt test and write-protect bank.
// Assumes the map header supplies every number.
package lcdirq_pkg;

    // The six interrupt flags, one bit per source.
    typedef struct packed {
        logic mem_fault;
        logic overwrite;
        logic underflow;
        logic frame_done;
        logic final_line;
        logic line;
    } lcdirq_flags_t;

    // A decoded APB request as seen in the access phase.
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic write;
        logic active;
    } lcdirq_req_t;

endpackage : lcdirq_pkg

// ==== hdl/lcdirq_top.sv ====
// APB register bank for LCD interrupt flags, their test forcing, and keyed write protection.
// Assumes one clock pclk, asynchronous active-low presetn, event inputs from logic on pclk.
// Assumes a master that holds its request until ready; side effects happen only on that edge.
`timescale 1ns/1ns
`default_nettype none
`include "lcdirq_map.svh"

// Function
// - Writing 1 to force bit 0 sets the line flag; zeros change nothing.
// - Writing 1 to force bit 1 sets the final-line flag.
// - Writing 1 to force bit 2 sets the frame-done flag.
// - Writing 1 to force bit 4 sets the underflow flag.
// - Writing 1 to force bit 5 sets the overwrite flag.
// - Writing 1 to force bit 6 sets the memory-fault flag.
// - Raw view reads every present flag at the same positions, ignoring the mask.
// - Protect bit 1 with correct key turns write protection on.
// - Protect bit 0 with correct key turns write protection off.
// - A wrong key leaves the protect bit unchanged.
// - The key field always reads back as zero.
// - Protection covers fifteen configuration words: control, timing, frame, FIFO, toggle, dither.
// - Violation bit is set if any violation happened since the last report read.
// - While violation is set, bits 23..8 hold the offending register offset.
// - Reading the report returns it, then clears flag and source.
// - Writing 1 to a clear bit clears that flag; 0 does nothing.
// - Writing 1 to an enable bit sets that mask bit.
module lcdirq_top
    import lcdirq_pkg::*;
#(
    parameter int CFG_COUNT = `LCDIRQ_CFG_COUNT
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire lcdirq_flags_t event_in,
    output logic irq,
    output logic protect_on,
    output logic [CFG_COUNT-1:0][31:0] cfg_words
);

    // Places the six flags at their register bit positions.
    // Bit 3 and the upper bits stay zero, so reads never show a flag that does not exist.
    function automatic logic [31:0] flags_to_word(input lcdirq_flags_t f);
        logic [31:0] w;
        w = `LCDIRQ_RST_WORD;
        w[`LCDIRQ_BIT_LINE] = f.line;
        w[`LCDIRQ_BIT_FINAL_LINE] = f.final_line;
        w[`LCDIRQ_BIT_FRAME_DONE] = f.frame_done;
        w[`LCDIRQ_BIT_UNDERFLOW] = f.underflow;
        w[`LCDIRQ_BIT_OVERWRITE] = f.overwrite;
        w[`LCDIRQ_BIT_MEM_FAULT] = f.mem_fault;
        return w;
    endfunction : flags_to_word

    // Picks the six flags out of a written word; other bits are ignored.
    // Ignoring bit 3 keeps a careless all-ones write from touching anything undefined.
    function automatic lcdirq_flags_t word_to_flags(input logic [31:0] w);
        lcdirq_flags_t f;
        f.line = w[`LCDIRQ_BIT_LINE];
        f.final_line = w[`LCDIRQ_BIT_FINAL_LINE];
        f.frame_done = w[`LCDIRQ_BIT_FRAME_DONE];
        f.underflow = w[`LCDIRQ_BIT_UNDERFLOW];
        f.overwrite = w[`LCDIRQ_BIT_OVERWRITE];
        f.mem_fault = w[`LCDIRQ_BIT_MEM_FAULT];
        return f;
    endfunction : word_to_flags

    // Tells whether an address falls on one of the protected configuration words.
    // A misaligned address is refused here, so it can neither write a word nor raise a violation.
    function automatic logic is_cfg_addr(input logic [31:0] a);
        logic [31:0] rel;
        rel = a - `LCDIRQ_ADDR_CFG_BASE;
        return (rel[1:0] == 2'h0) && (rel[31:2] < 30'(CFG_COUNT));
    endfunction : is_cfg_addr

    localparam int IDX_W = `LCDIRQ_CFG_IDX_W;

    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic irq_ff;
    logic protect_on_ff;
    lcdirq_flags_t flags_ff;
    lcdirq_flags_t mask_ff;
    logic violation_seen_ff;
    logic [15:0] violation_source_ff;
    logic [CFG_COUNT-1:0][31:0] cfg_ff;

    lcdirq_req_t req;
    logic first_access;
    logic commit;
    logic wr_commit;
    logic rd_commit;
    logic addr_known;
    logic [31:0] rd_word;
    logic [31:0] cfg_rel;
    logic [IDX_W-1:0] cfg_idx;
    logic cfg_hit;
    logic key_ok;
    logic cfg_blocked;
    lcdirq_flags_t wr_flags;
    lcdirq_flags_t nxt_flags;
    lcdirq_flags_t nxt_mask;
    logic wr_force;
    logic wr_clear;
    logic wr_enable_set;
    logic wr_enable_clr;
    logic wr_prot_mode;
    logic rd_report;

    // Bundles the bus request; the first access cycle prepares the answer, the next one commits it.
    // Committing on the ready edge keeps a read-clear from firing twice on one access.
    assign req.addr = paddr;
    assign req.wdata = pwdata;
    assign req.write = pwrite;
    assign req.active = psel & penable;
    assign first_access = req.active & ~pready_ff;
    assign commit = req.active & pready_ff;
    assign wr_commit = commit & req.write;
    assign rd_commit = commit & ~req.write;
    assign wr_flags = word_to_flags(req.wdata);

    // Decodes the protected configuration word index.
    // The same decode drives the lock check, the word write and the violation record.
    assign cfg_hit = is_cfg_addr(req.addr);
    assign cfg_rel = req.addr - `LCDIRQ_ADDR_CFG_BASE;
    assign cfg_idx = cfg_rel[IDX_W+1:2];
    assign key_ok = (req.wdata[`LCDIRQ_KEY_MSB:`LCDIRQ_KEY_LSB] == `LCDIRQ_KEY_VALUE);
    assign cfg_blocked = wr_commit & cfg_hit & protect_on_ff;

    // Register strobes, one for each side effect, all on the commit edge.
    assign wr_force = wr_commit & (req.addr == `LCDIRQ_ADDR_FORCE);
    assign wr_clear = wr_commit & (req.addr == `LCDIRQ_ADDR_CLEAR);
    assign wr_enable_set = wr_commit & (req.addr == `LCDIRQ_ADDR_ENABLE_SET);
    assign wr_enable_clr = wr_commit & (req.addr == `LCDIRQ_ADDR_ENABLE_CLR);
    assign wr_prot_mode = wr_commit & (req.addr == `LCDIRQ_ADDR_PROT_MODE);
    assign rd_report = rd_commit & (req.addr == `LCDIRQ_ADDR_PROT_REPORT);

    // Builds the read answer and flags unmapped addresses.
    // Write-only words read as zero without error; only an address nothing decodes is refused.
    always_comb
    begin
        rd_word = `LCDIRQ_RST_WORD;
        addr_known = 1'b1;
        if (cfg_hit)
        begin
            rd_word = cfg_ff[cfg_idx];
        end
        else
        begin
            case (req.addr)
                `LCDIRQ_ADDR_ENABLE_SET, `LCDIRQ_ADDR_ENABLE_CLR,
                `LCDIRQ_ADDR_CLEAR, `LCDIRQ_ADDR_FORCE:
                    rd_word = `LCDIRQ_RST_WORD;
                `LCDIRQ_ADDR_MASK:
                    rd_word = flags_to_word(mask_ff);
                `LCDIRQ_ADDR_STATUS:
                    rd_word = flags_to_word(flags_ff & mask_ff);
                `LCDIRQ_ADDR_RAW:
                    rd_word = flags_to_word(flags_ff);
                `LCDIRQ_ADDR_PROT_MODE:
                begin
                    rd_word[`LCDIRQ_BIT_PROTECT_ON] = protect_on_ff;
                end
                `LCDIRQ_ADDR_PROT_REPORT:
                begin
                    rd_word[`LCDIRQ_BIT_VIOLATION_SEEN] = violation_seen_ff;
                    rd_word[`LCDIRQ_SRC_MSB:`LCDIRQ_SRC_LSB] = violation_source_ff;
                end
                default:
                    addr_known = 1'b0;
            endcase
        end
    end

    // Ready rises one cycle after the access phase starts, so every access has exactly one wait state.
    // The wait state gives the read multiplexer a whole cycle and keeps side effects on a single edge.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
        end
        else
        begin
            pready_ff <= first_access;
        end
    end

    // The error answer travels with ready and is raised only for an address that nothing decodes.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pslverr_ff <= first_access & ~addr_known;
        end
    end

    // Read data is captured in the wait state and then held until the next read answers.
    // Capturing before the commit edge means a read-clear cannot corrupt the word being returned.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff <= `LCDIRQ_RST_WORD;
        end
        else if (first_access && !req.write)
        begin
            prdata_ff <= rd_word;
        end
    end

    // Interrupt flags: sources, forcing and clearing; a set in the clearing cycle survives.
    // Events are merged after the clear so that a source pulse is never lost to a late clear.
    always_comb
    begin
        nxt_flags = flags_ff;
        if (wr_clear)
        begin
            nxt_flags = flags_ff & ~wr_flags;
        end
        nxt_flags = nxt_flags | event_in;
        if (wr_force)
        begin
            nxt_flags.line = nxt_flags.line | wr_flags.line;
            nxt_flags.final_line = nxt_flags.final_line | wr_flags.final_line;
            nxt_flags.frame_done = nxt_flags.frame_done | wr_flags.frame_done;
            nxt_flags.underflow = nxt_flags.underflow | wr_flags.underflow;
            nxt_flags.overwrite = nxt_flags.overwrite | wr_flags.overwrite;
            nxt_flags.mem_fault = nxt_flags.mem_fault | wr_flags.mem_fault;
        end
    end

    // Interrupt mask: enable writes set bits, disable writes clear them.
    always_comb
    begin
        nxt_mask = mask_ff;
        if (wr_enable_set)
        begin
            nxt_mask = mask_ff | wr_flags;
        end
        else if (wr_enable_clr)
        begin
            nxt_mask = mask_ff & ~wr_flags;
        end
    end

    // Sticky interrupt flags.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flags_ff <= `LCDIRQ_RST_FLAGS;
        end
        else
        begin
            flags_ff <= nxt_flags;
        end
    end

    // Interrupt mask bits.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mask_ff <= `LCDIRQ_RST_FLAGS;
        end
        else
        begin
            mask_ff <= nxt_mask;
        end
    end

    // Interrupt output, built from next values so that it changes on the same edge as the flags.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_ff <= 1'b0;
        end
        else
        begin
            irq_ff <= |(nxt_flags & nxt_mask);
        end
    end

    // Protect enable changes only with the correct key.
    // A wrong key aborts the whole write, so a stray store cannot unlock the configuration.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            protect_on_ff <= 1'b0;
        end
        else if (wr_prot_mode && key_ok)
        begin
            protect_on_ff <= req.wdata[`LCDIRQ_BIT_PROTECT_ON];
        end
    end

    // Violation flag: a new violation wins over the clearing read in the same cycle.
    // Letting the set win means software never misses a violation that lands on its own read.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            violation_seen_ff <= 1'b0;
        end
        else if (cfg_blocked)
        begin
            violation_seen_ff <= 1'b1;
        end
        else if (rd_report)
        begin
            violation_seen_ff <= 1'b0;
        end
    end

    // Violation source: low address half of the last blocked write, cleared together with the flag.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            violation_source_ff <= 16'h0000;
        end
        else if (cfg_blocked)
        begin
            violation_source_ff <= req.addr[15:0];
        end
        else if (rd_report)
        begin
            violation_source_ff <= 16'h0000;
        end
    end

    // Protected configuration words, written only while unlocked.
    // A blocked write never reaches these words; it is only recorded in the violation report.
    genvar gi;
    generate
        for (gi = 0; gi < CFG_COUNT; gi++)
        begin : g_cfg
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    cfg_ff[gi] <= `LCDIRQ_RST_WORD;
                end
                else if (wr_commit && cfg_hit && !protect_on_ff && cfg_idx == IDX_W'(gi))
                begin
                    cfg_ff[gi] <= req.wdata;
                end
            end
        end
    endgenerate

    // Every output comes straight from a flip-flop.
    // No output passes through logic, so the outputs carry no glitches into the controller.
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
    assign protect_on = protect_on_ff;
    assign cfg_words = cfg_ff;

endmodule : lcdirq_top
`default_nettype wire

// ==== tb/lcdirq_top_sva.sv ====
// Assertions on the ports of the LCD interrupt and write-protect bank.
// Assumes it is bound into every instance of the top module by the bind at the foot.
`timescale 1ns/1ns
`default_nettype none
`include "lcdirq_map.svh"
module lcdirq_top_sva
    import lcdirq_pkg::*;
#(
    parameter int CFG_COUNT = 15
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire lcdirq_flags_t event_in,
    input wire logic irq,
    input wire logic protect_on,
    input wire logic [CFG_COUNT-1:0][31:0] cfg_words
);
    // Every check runs on the bus clock and rests during reset.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completed accesses, taken at the edge where pready is high.
    sequence wr_at(logic [31:0] a);
        psel && penable && pready && pwrite && paddr == a;
    endsequence
    sequence rd_at(logic [31:0] a);
        psel && penable && pready && !pwrite && paddr == a;
    endsequence
    sequence cfg_wr;
        psel && penable && pready && pwrite && paddr[1:0] == 2'h0 && paddr >= `LCDIRQ_ADDR_CFG_BASE
            && paddr < `LCDIRQ_ADDR_CFG_BASE + 32'(4 * CFG_COUNT);
    endsequence
    rdy_wait_a: assert property ($rose(penable) && psel |=> pready) else $error("pready not one cycle after penable");
    prot_set_a: assert property (wr_at(`LCDIRQ_ADDR_PROT_MODE) ##0 pwdata[31:8] == `LCDIRQ_KEY_VALUE
        |=> protect_on == $past(pwdata[0])) else $error("protect state not taken with key");
    prot_key_a: assert property (wr_at(`LCDIRQ_ADDR_PROT_MODE) ##0 pwdata[31:8] != `LCDIRQ_KEY_VALUE
        |=> $stable(protect_on)) else $error("protect state changed by wrong key");
    key_zero_a: assert property (rd_at(`LCDIRQ_ADDR_PROT_MODE) |-> prdata == {31'h0, protect_on})
        else $error("protect mode read wrong");
    cfg_lock_a: assert property (cfg_wr ##0 protect_on |=> $stable(cfg_words))
        else $error("locked word changed");
    cfg_open_a: assert property (cfg_wr ##0 !protect_on |=> cfg_words[$past(paddr[5:2])] == $past(pwdata))
        else $error("open word not written");
    src_idle_a: assert property (rd_at(`LCDIRQ_ADDR_PROT_REPORT) ##0 !prdata[0] |-> prdata == 32'h0)
        else $error("source field set without violation");
    mask_irq_a: assert property (rd_at(`LCDIRQ_ADDR_MASK) ##0 prdata == 32'h0 |-> !irq)
        else $error("irq high with empty mask");
    stat_irq_a: assert property (rd_at(`LCDIRQ_ADDR_STATUS) ##0 prdata != 32'h0 |-> irq)
        else $error("irq low with active status");
    bad_addr_a: assert property (psel && penable && pready && paddr == 32'h0050_0900 |-> pslverr)
        else $error("unmapped access not refused");
endmodule : lcdirq_top_sva
bind lcdirq_top lcdirq_top_sva #(.CFG_COUNT(CFG_COUNT)) u_lcdirq_top_sva (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_in(event_in), .irq(irq), .protect_on(protect_on),
    .cfg_words(cfg_words));
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the LCD interrupt and write-protect bank.
// Assumes the APB walk of one wait state; the bench still waits on pready.
`timescale 1ns/1ns
`default_nettype none
`include "lcdirq_map.svh"
module testbench;
    import lcdirq_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    lcdirq_flags_t event_in = '0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, protect_on;
    logic [14:0][31:0] cfg_words;
    logic [31:0] rd, want;
    logic err;
    int miscompares = 0;
    int n_compared = 0;
    int fbit[6] = '{0, 1, 2, 4, 5, 6};

    lcdirq_top u_lcdirq_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .event_in(event_in), .irq(irq), .protect_on(protect_on), .cfg_words(cfg_words));

    // Clock of 100 ns period.
    initial
    begin
        forever #50 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp_v);
        n_compared++;
        if (seen !== exp_v)
        begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp_v);
        end
    endtask : check

    // One APB transfer; read data and error are taken at the pready edge.
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            miscompares++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [31:0] a, input logic [31:0] exp_v);
        apb(1'b0, a, 32'h0);
        check(rd, exp_v);
    endtask : rchk

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up

    // Cuts a hung run short.
    initial
    begin
        #(3000 * 100);
        miscompares++;
        wrap_up();
    end

    // Main test sequence.
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rchk(`LCDIRQ_ADDR_RAW, 32'h0);
        rchk(`LCDIRQ_ADDR_PROT_REPORT, 32'h0);
        $display("Test reset done");
        want = 32'h0;
        foreach (fbit[i])
        begin
            apb(1'b1, `LCDIRQ_ADDR_FORCE, 32'h1 << fbit[i]);
            want |= 32'h1 << fbit[i];
            rchk(`LCDIRQ_ADDR_RAW, want);
        end
        apb(1'b1, `LCDIRQ_ADDR_FORCE, 32'h08);
        rchk(`LCDIRQ_ADDR_RAW, 32'h77);
        apb(1'b1, `LCDIRQ_ADDR_CLEAR, 32'h05);
        rchk(`LCDIRQ_ADDR_RAW, 32'h72);
        apb(1'b1, `LCDIRQ_ADDR_CLEAR, 32'h72);
        rchk(`LCDIRQ_ADDR_RAW, 32'h0);
        $display("Test force done");
        apb(1'b1, `LCDIRQ_ADDR_ENABLE_SET, 32'h10);
        rchk(`LCDIRQ_ADDR_MASK, 32'h10);
        check(32'(irq), 32'h0);
        @(posedge pclk);
        event_in.underflow <= 1'b1;
        @(posedge pclk);
        event_in.underflow <= 1'b0;
        rchk(`LCDIRQ_ADDR_RAW, 32'h10);
        rchk(`LCDIRQ_ADDR_STATUS, 32'h10);
        check(32'(irq), 32'h1);
        apb(1'b1, `LCDIRQ_ADDR_FORCE, 32'h01);
        rchk(`LCDIRQ_ADDR_STATUS, 32'h10);
        apb(1'b1, `LCDIRQ_ADDR_ENABLE_CLR, 32'h10);
        rchk(`LCDIRQ_ADDR_MASK, 32'h0);
        @(negedge pclk);
        check(32'(irq), 32'h0);
        rchk(`LCDIRQ_ADDR_RAW, 32'h11);
        $display("Test interrupt done");
        apb(1'b1, `LCDIRQ_ADDR_CFG_BASE + 32'hC, 32'hA5A5_0003);
        @(negedge pclk);
        check(cfg_words[3], 32'hA5A5_0003);
        apb(1'b1, `LCDIRQ_ADDR_PROT_MODE, 32'h1234_5601);
        rchk(`LCDIRQ_ADDR_PROT_MODE, 32'h0);
        apb(1'b1, `LCDIRQ_ADDR_PROT_MODE, {`LCDIRQ_KEY_VALUE, 8'h01});
        rchk(`LCDIRQ_ADDR_PROT_MODE, 32'h1);
        check(32'(protect_on), 32'h1);
        apb(1'b1, `LCDIRQ_ADDR_CFG_BASE + 32'hC, 32'h0BAD_0BAD);
        @(negedge pclk);
        check(cfg_words[3], 32'hA5A5_0003);
        apb(1'b1, `LCDIRQ_ADDR_CFG_BASE + 32'h38, 32'h1);
        @(negedge pclk);
        check(cfg_words[14], 32'h0);
        rchk(`LCDIRQ_ADDR_PROT_REPORT, 32'h0008_3801);
        rchk(`LCDIRQ_ADDR_PROT_REPORT, 32'h0);
        apb(1'b1, `LCDIRQ_ADDR_PROT_MODE, 32'h0);
        rchk(`LCDIRQ_ADDR_PROT_MODE, 32'h1);
        apb(1'b1, `LCDIRQ_ADDR_PROT_MODE, {`LCDIRQ_KEY_VALUE, 8'h00});
        rchk(`LCDIRQ_ADDR_PROT_MODE, 32'h0);
        check(32'(protect_on), 32'h0);
        apb(1'b1, `LCDIRQ_ADDR_CFG_BASE + 32'h38, 32'h5A5A);
        @(negedge pclk);
        check(cfg_words[14], 32'h5A5A);
        rchk(32'h0050_0900, 32'h0);
        check(32'(err), 32'h1);
        $display("Test protect done");
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
